// ==== design/usu_pkg.sv ====
// Package for the universal serial shift unit: register map, field layout,
// reset values and encodings shared by the unit and its helpers.
// Assumes an 8-bit I/O register space addressed by a 6-bit address.
package usu_pkg;

  localparam int          DATA_W        = 8;
  localparam int          CNT_W         = 4;
  localparam int          ADDR_W        = 6;

  // Register addresses in the I/O space
  localparam logic [5:0]  ADDR_CTRL     = 6'h0d;
  localparam logic [5:0]  ADDR_DATA     = 6'h0f;

  // Control register fields
  localparam int          BIT_START_IE  = 7;
  localparam int          BIT_OVF_IE    = 6;
  localparam int          WM_HI         = 5;
  localparam int          WM_LO         = 4;
  localparam int          CS_HI         = 3;
  localparam int          CS_LO         = 2;
  localparam int          BIT_CLK_STB   = 1;
  localparam int          BIT_TOG_STB   = 0;
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [7:0]  CTRL_RW_MASK  = 8'hfc;

  // Wire mode codes
  localparam logic [1:0]  WM_OFF        = 2'h0;
  localparam logic [1:0]  WM_THREE      = 2'h1;

  // Clock source codes
  localparam logic [1:0]  CS_SOFT       = 2'h0;
  localparam logic [1:0]  CS_TIMER      = 2'h1;
  localparam logic [1:0]  CS_EXT_POS    = 2'h2;
  localparam logic [1:0]  CS_EXT_NEG    = 2'h3;

  // Reset values and counter maximum
  localparam logic [7:0]  SHIFT_RST     = 8'h00;
  localparam logic [3:0]  CNT_RST       = 4'h0;
  localparam logic [3:0]  CNT_MAX       = 4'hf;

endpackage

// ==== design/usu_sync_edge.sv ====
// Two-flop synchroniser with edge detection, one lane per input bit.
// Assumes asynchronous inputs; edges are found behind the second flop.
`timescale 1ns/10ps
module usu_sync_edge #(
  parameter int W = 2
) (
  input  wire logic         clk_sys,  // System clock
  input  wire logic         rst_n,    // Async reset, active low
  input  wire logic [W-1:0] sig_in,   // Asynchronous inputs
  output logic      [W-1:0] level,    // Synchronised level
  output logic      [W-1:0] rise,     // One-cycle rising edge pulse
  output logic      [W-1:0] fall      // One-cycle falling edge pulse
);

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_lane
      logic s1_q;
      logic s2_q;
      logic s3_q;
      always_ff @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
        begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end
        else
        begin
          s1_q <= sig_in[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end
      assign level[i] = s2_q;
      assign rise[i]  = s2_q & ~s3_q;
      assign fall[i]  = ~s2_q & s3_q;
    end
  endgenerate

endmodule // usu_sync_edge

// ==== design/usu_buf.sv ====
// Small circular buffer with valid/ready on both sides.
// Assumes DEPTH is a power of two; default holds two words.
`timescale 1ns/10ps
module usu_buf #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input  wire logic         clk_sys,   // System clock
  input  wire logic         rst_n,     // Async reset, active low
  input  wire logic         in_valid,  // Word offered
  output logic              in_ready,  // Room for a word
  input  wire logic [W-1:0] in_data,   // Word in
  output logic              out_valid, // Word available
  input  wire logic         out_ready, // Drain accepts
  output logic      [W-1:0] out_data   // Word out
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] wr_d;
  logic [PW-1:0] rd_q;
  logic [PW-1:0] rd_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          push;
  logic          pop;
  logic [W-1:0]  mem_d [DEPTH];
  logic [W-1:0]  head_q;
  logic [W-1:0]  head_d;
  logic          valid_q;
  logic          valid_d;

  always_comb
  begin
    push  = in_valid & in_ready;
    pop   = out_valid & out_ready;
    wr_d  = push ? PW'(wr_q + 1'b1) : wr_q;
    rd_d  = pop ? PW'(rd_q + 1'b1) : rd_q;
    cnt_d = CW'(cnt_q + CW'(push) - CW'(pop));
    mem_d = mem_q;
    if (push)
      mem_d[wr_q] = in_data;
    // Head word and valid held in flops so the outputs need no decode
    head_d  = mem_d[rd_d];
    valid_d = (cnt_d != '0);
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
      head_q  <= '0;
      valid_q <= 1'b0;
    end
    else
    begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
      head_q  <= head_d;
      valid_q <= valid_d;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    mem_q <= mem_d;
  end

  assign in_ready  = (cnt_q != CW'(DEPTH));
  assign out_valid = valid_q;
  assign out_data  = head_q;

endmodule // usu_buf

// ==== design/usu_shift_unit.sv ====
// Universal serial shift unit: shift register, 4-bit clock counter,
// control register and three-wire pin logic.
// Assumes a CPU I/O register port on clk_sys; pins are asynchronous.
//
// Behaviour
// - 8-bit shift register, read and written directly, completed words also go to a two-word receive buffer while it has room
// - Shift register MSB drives the data output pin selected by wire mode
// - With external clocks, output latch changes on the edge opposite to input sampling
// - Serial input always sampled from the data input pin
// - 4-bit counter advances once per clock event from any source, except an internal-source final event while the buffer is full
// - Clock source select field picks the event source
// - External source plus clock strobe one lets toggle writes make clocks
// - External clock pin drives the counter even with wire mode zero
// - Control register layout: enables, wire mode, clock select, two strobes
// - Pending start event requests service once enable and global enable set
// - Pending overflow event requests service once enable and global enable set
// - Wire mode changes outputs only; inputs keep working
// - Wire mode zero leaves pins as plain port pins
// - Three-wire: data output replaces port bit, direction and pull-up stay port's
// - Data input and clock pin port operation left untouched
// - Toggle strobe write toggles the clock pin's port output bit
`timescale 1ns/10ps
module usu_shift_unit #(
  parameter int DATA_W = usu_pkg::DATA_W,
  parameter int CNT_W  = usu_pkg::CNT_W
) (
  input  wire logic              clk_sys,           // System clock, 20 MHz
  input  wire logic              rst_n,             // Async reset, active low
  input  wire logic [5:0]        io_addr,           // I/O register address
  input  wire logic              io_wr,             // Register write strobe
  input  wire logic              io_rd,             // Register read strobe
  input  wire logic [7:0]        io_wdata,          // Write data
  output logic      [7:0]        io_rdata,          // Read data, valid after io_rd
  input  wire logic              global_irq_en,     // Global interrupt enable
  input  wire logic              timer0_match,      // Timer 0 compare match pulse
  input  wire logic              start_detect,      // Start condition event pulse
  input  wire logic              start_flag_clr,    // Clear start flag
  input  wire logic              ovf_flag_clr,      // Clear overflow flag
  input  wire logic              serial_data_input, // Data input pin
  input  wire logic              sck_pin_i,         // Clock pin level
  input  wire logic              port_do_bit,       // Port output bit, data pin
  input  wire logic              port_do_dir,       // Port direction bit, data pin
  input  wire logic              port_ck_bit,       // Port output bit, clock pin
  input  wire logic              port_ck_dir,       // Port direction bit, clock pin
  output logic                   do_pin_o,          // Data output pin value
  output logic                   do_pin_oe,         // Data output pin enable
  output logic                   do_pull_up,        // Data pin pull-up enable
  output logic                   sck_pin_o,         // Clock pin value
  output logic                   sck_pin_oe,        // Clock pin enable
  output logic                   ck_toggle,         // Pulse: toggle clock port bit
  output logic      [DATA_W-1:0] rx_data,           // Completed word
  output logic                   rx_valid,          // Completed word available
  input  wire logic              rx_ready,          // Receiver takes word
  output logic                   start_irq_req,     // Start service request
  output logic                   ovf_irq_req        // Overflow service request
);

  logic [7:0]        ctrl_q;
  logic [7:0]        ctrl_d;
  logic [DATA_W-1:0] shreg_q;
  logic [DATA_W-1:0] shreg_d;
  logic [CNT_W-1:0]  cnt_q;
  logic [CNT_W-1:0]  cnt_d;
  logic              latch_q;
  logic              latch_d;
  logic              latch_pend_q;
  logic              latch_pend_d;
  logic              soft_ext_q;
  logic              soft_ext_d;
  logic              phase_q;
  logic              phase_d;
  logic              start_flag_q;
  logic              start_flag_d;
  logic              ovf_flag_q;
  logic              ovf_flag_d;
  logic              start_req_q;
  logic              start_req_d;
  logic              ovf_req_q;
  logic              ovf_req_d;
  logic [7:0]        rdata_q;
  logic [7:0]        rdata_d;
  logic              do_o_q;
  logic              do_o_d;
  logic              do_oe_q;
  logic              do_oe_d;
  logic              pull_q;
  logic              pull_d;
  logic              sck_o_q;
  logic              sck_oe_q;
  logic              tog_q;
  logic              tog_d;

  logic [1:0]        pin_lvl;
  logic [1:0]        pin_rise;
  logic [1:0]        pin_fall;
  logic              ctrl_wr;
  logic              data_wr;
  logic              clk_stb;
  logic              tog_stb;
  logic              ext_sel;
  logic              count_ev;
  logic              shift_ev;
  logic              latch_ev;
  logic              ovf_ev;
  logic              buf_ready;
  logic [1:0]        cs;
  logic [1:0]        wm;

  // Pin inputs: bit 1 clock pin, bit 0 data input
  usu_sync_edge #(
    .W (2)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .sig_in  ({sck_pin_i, serial_data_input}),
    .level   (pin_lvl),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  // Completed words wait here; with internal sources a slow receiver loses none
  usu_buf #(
    .W     (DATA_W),
    .DEPTH (2)
  ) u_buf (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (ovf_ev),
    .in_ready  (buf_ready),
    .in_data   (shreg_d),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  always_comb
  begin
    cs       = ctrl_q[usu_pkg::CS_HI:usu_pkg::CS_LO];
    wm       = ctrl_q[usu_pkg::WM_HI:usu_pkg::WM_LO];
    ctrl_wr  = io_wr && (io_addr == usu_pkg::ADDR_CTRL);
    data_wr  = io_wr && (io_addr == usu_pkg::ADDR_DATA);
    clk_stb  = ctrl_wr && io_wdata[usu_pkg::BIT_CLK_STB];
    tog_stb  = ctrl_wr && io_wdata[usu_pkg::BIT_TOG_STB];
    ext_sel  = cs[1];
    count_ev = 1'b0;
    shift_ev = 1'b0;
    latch_ev = 1'b0;
    phase_d  = phase_q;

    // Strobes are not stored; only bits 7:2 hold state
    ctrl_d = ctrl_wr ? (io_wdata & usu_pkg::CTRL_RW_MASK) : ctrl_q;
    // Strobe writes become the clock until a control write has CS_HI or the clock strobe bit clear
    soft_ext_d = soft_ext_q;
    if (ctrl_wr)
      soft_ext_d = io_wdata[usu_pkg::CS_HI] && io_wdata[usu_pkg::BIT_CLK_STB];

    // Event source per clock select, pin events seen in every wire mode
    case (cs)
      usu_pkg::CS_SOFT:
      begin
        count_ev = clk_stb;
        shift_ev = clk_stb;
      end
      usu_pkg::CS_TIMER:
      begin
        count_ev = timer0_match;
        shift_ev = timer0_match;
      end
      usu_pkg::CS_EXT_POS,
      usu_pkg::CS_EXT_NEG:
      begin
        if (soft_ext_q)
        begin
          // Each toggle write is one edge; alternate sample and output phases
          count_ev = tog_stb;
          shift_ev = tog_stb && !phase_q;
          latch_ev = tog_stb && phase_q;
          if (tog_stb)
            phase_d = ~phase_q;
        end
        else
        begin
          // Counter sees both pin edges, independent of wire mode
          count_ev = pin_rise[1] | pin_fall[1];
          shift_ev = (cs == usu_pkg::CS_EXT_POS) ? pin_rise[1] : pin_fall[1];
          latch_ev = (cs == usu_pkg::CS_EXT_POS) ? pin_fall[1] : pin_rise[1];
        end
      end
      default:
      begin
        count_ev = 1'b0;
        shift_ev = 1'b0;
      end
    endcase

    // Internal sources hold off the final edge while the buffer is full
    if (!ext_sel && !buf_ready && (cnt_q == usu_pkg::CNT_MAX))
    begin
      count_ev = 1'b0;
      shift_ev = 1'b0;
    end
    if (ctrl_wr && !soft_ext_d)
      phase_d = 1'b0;

    // Software write wins over a shift in the same cycle
    shreg_d = shreg_q;
    if (data_wr)
      shreg_d = io_wdata[DATA_W-1:0];
    else if (shift_ev)
      shreg_d = {shreg_q[DATA_W-2:0], pin_lvl[0]};

    cnt_d  = count_ev ? CNT_W'(cnt_q + 1'b1) : cnt_q;
    ovf_ev = count_ev && (cnt_q == usu_pkg::CNT_MAX);

    // Internal sources update the output one cycle after the shift
    latch_pend_d = shift_ev && !ext_sel;
    latch_d      = latch_q;
    if (latch_ev || latch_pend_q)
      latch_d = shreg_q[DATA_W-1];
    // Latch open in the idle clock phase, so a new word shows its MSB at once, except with CS_EXT_NEG
    if (data_wr && (cs != usu_pkg::CS_EXT_NEG))
      latch_d = io_wdata[DATA_W-1];

    // Sticky flags: a new event beats a clear in the same cycle
    start_flag_d = start_detect | (start_flag_q & ~start_flag_clr);
    ovf_flag_d   = ovf_ev | (ovf_flag_q & ~ovf_flag_clr);
    start_req_d  = start_flag_d && ctrl_d[usu_pkg::BIT_START_IE] && global_irq_en;
    ovf_req_d    = ovf_flag_d && ctrl_d[usu_pkg::BIT_OVF_IE] && global_irq_en;

    // Data pin: three-wire overrides value only; direction and pull-up stay port's
    do_oe_d = port_do_dir;
    pull_d  = !port_do_dir && port_do_bit;
    if (wm == usu_pkg::WM_THREE)
      do_o_d = latch_d;
    else
      do_o_d = port_do_bit;
    tog_d = tog_stb;

    rdata_d = rdata_q;
    if (io_rd)
    begin
      if (io_addr == usu_pkg::ADDR_CTRL)
        rdata_d = ctrl_q & usu_pkg::CTRL_RW_MASK;
      else if (io_addr == usu_pkg::ADDR_DATA)
        rdata_d = shreg_q;
      else
        rdata_d = 8'h00;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q       <= usu_pkg::CTRL_RST;
      shreg_q      <= usu_pkg::SHIFT_RST;
      cnt_q        <= usu_pkg::CNT_RST;
      latch_q      <= 1'b0;
      latch_pend_q <= 1'b0;
      soft_ext_q   <= 1'b0;
      phase_q      <= 1'b0;
      start_flag_q <= 1'b0;
      ovf_flag_q   <= 1'b0;
      start_req_q  <= 1'b0;
      ovf_req_q    <= 1'b0;
      rdata_q      <= 8'h00;
      do_o_q       <= 1'b0;
      do_oe_q      <= 1'b0;
      pull_q       <= 1'b0;
      sck_o_q      <= 1'b0;
      sck_oe_q     <= 1'b0;
      tog_q        <= 1'b0;
    end
    else
    begin
      ctrl_q       <= ctrl_d;
      shreg_q      <= shreg_d;
      cnt_q        <= cnt_d;
      latch_q      <= latch_d;
      latch_pend_q <= latch_pend_d;
      soft_ext_q   <= soft_ext_d;
      phase_q      <= phase_d;
      start_flag_q <= start_flag_d;
      ovf_flag_q   <= ovf_flag_d;
      start_req_q  <= start_req_d;
      ovf_req_q    <= ovf_req_d;
      rdata_q      <= rdata_d;
      do_o_q       <= do_o_d;
      do_oe_q      <= do_oe_d;
      pull_q       <= pull_d;
      sck_o_q      <= port_ck_bit;
      sck_oe_q     <= port_ck_dir;
      tog_q        <= tog_d;
    end
  end

  assign io_rdata      = rdata_q;
  assign do_pin_o      = do_o_q;
  assign do_pin_oe     = do_oe_q;
  assign do_pull_up    = pull_q;
  assign sck_pin_o     = sck_o_q;
  assign sck_pin_oe    = sck_oe_q;
  assign ck_toggle     = tog_q;
  assign start_irq_req = start_req_q;
  assign ovf_irq_req   = ovf_req_q;

endmodule // usu_shift_unit

// ==== test/usu_shift_monitor.sv ====
// Checker for the serial shift unit, bound to its top module.
// Assumes one clock domain and the register map of usu_pkg.
`timescale 1ns/10ps
module usu_shift_monitor #(
  parameter int DATA_W = 8
) (
  input wire logic              clk_sys,        // Clock
  input wire logic              rst_n,          // Reset
  input wire logic [5:0]        io_addr,        // Address
  input wire logic              io_wr,          // Write
  input wire logic              io_rd,          // Read
  input wire logic [7:0]        io_wdata,       // Write data
  input wire logic [7:0]        io_rdata,       // Read data
  input wire logic              global_irq_en,  // Global enable
  input wire logic              start_detect,   // Start event
  input wire logic              start_flag_clr, // Start clear
  input wire logic              port_do_bit,    // Data port bit
  input wire logic              port_do_dir,    // Data direction
  input wire logic              port_ck_bit,    // Clock port bit
  input wire logic              port_ck_dir,    // Clock direction
  input wire logic              do_pin_oe,      // Data enable
  input wire logic              do_pull_up,     // Pull-up
  input wire logic              sck_pin_o,      // Clock out
  input wire logic              sck_pin_oe,     // Clock enable
  input wire logic              ck_toggle,      // Toggle pulse
  input wire logic [DATA_W-1:0] rx_data,        // Word out
  input wire logic              rx_valid,       // Word valid
  input wire logic              rx_ready,       // Word taken
  input wire logic              start_irq_req,  // Start request
  input wire logic              ovf_irq_req     // Overflow request
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_ctl_wr;
    io_wr && io_addr == usu_pkg::ADDR_CTRL;
  endsequence
  sequence s_start_en;
    s_ctl_wr ##0 (io_wdata[7] && global_irq_en && !start_flag_clr);
  endsequence

  a_pin_follow: assert property (
    $past(rst_n) |-> do_pin_oe == $past(port_do_dir) && do_pull_up == (!$past(port_do_dir) && $past(port_do_bit)))
    else $error("data pin drive wrong");
  a_sck_follow: assert property (
    $past(rst_n) |-> sck_pin_o == $past(port_ck_bit) && sck_pin_oe == $past(port_ck_dir))
    else $error("clock pin drive wrong");
  a_toggle_pulse: assert property (
    s_ctl_wr ##0 io_wdata[0] |=> ck_toggle) else $error("toggle pulse missing");
  a_toggle_cause: assert property (
    ck_toggle |-> $past(io_wr) && $past(io_addr) == usu_pkg::ADDR_CTRL && $past(io_wdata[0]))
    else $error("toggle pulse without write");
  a_ovf_gate: assert property (
    ovf_irq_req |-> $past(global_irq_en)) else $error("overflow request without global enable");
  a_start_pend: assert property (
    start_detect && !start_flag_clr ##1 s_start_en |=> start_irq_req) else $error("pending start not served");
  a_start_clear: assert property (
    start_flag_clr && !start_detect |=> !start_irq_req) else $error("start request after clear");
  a_strobe_zero: assert property (
    io_rd && io_addr == usu_pkg::ADDR_CTRL |=> io_rdata[1:0] == 2'h0) else $error("strobe bits read nonzero");
  a_rx_hold: assert property (
    rx_valid && !rx_ready |=> rx_valid && $stable(rx_data)) else $error("stalled word lost");
endmodule // usu_shift_monitor

bind usu_shift_unit usu_shift_monitor #(.DATA_W(DATA_W)) mon_u (.clk_sys, .rst_n, .io_addr, .io_wr, .io_rd,
  .io_wdata, .io_rdata, .global_irq_en, .start_detect, .start_flag_clr, .port_do_bit, .port_do_dir, .port_ck_bit,
  .port_ck_dir, .do_pin_oe, .do_pull_up, .sck_pin_o, .sck_pin_oe, .ck_toggle, .rx_data, .rx_valid, .rx_ready,
  .start_irq_req, .ovf_irq_req);

// ==== test/usu_serial_master_model.sv ====
// Behavioural three-wire serial master on the unit's clock and data pins.
// Assumes the bench calls its tasks; the clock stands low between frames.
`timescale 1ns/10ps
module usu_serial_master_model (
  output logic      sck, // Serial clock
  output logic      sdo, // Data to the unit
  input  wire logic sdi  // Data from the unit
);
  initial
  begin
    sck = 1'b0;
    sdo = 1'b0;
  end

  task automatic hold(input logic v);
    sdo = v;
  endtask

  // MSB first, data set in the low phase, unit data taken at each rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    #7;
    for (int i = 7; i >= 0; i--)
    begin
      sdo = tx[i];
      #100;
      rx = {rx[6:0], sdi};
      sck = 1'b1;
      #200;
      sck = 1'b0;
      #100;
    end
    sdo = ~sdo;
  endtask
endmodule // usu_serial_master_model

// ==== test/testbench.sv ====
// Self-checking bench for the serial shift unit.
// Assumes the serial master model on the pins and the bound checker.
`timescale 1ns/10ps
module testbench;
  localparam logic [7:0] PRE = 8'ha5;
  logic       clk_sys, rst_n = 0, io_wr = 0, io_rd = 0, global_irq_en = 0, timer0_match = 0;
  logic       start_detect = 0, start_flag_clr = 0, ovf_flag_clr = 0, rx_ready = 0;
  logic       port_do_bit = 0, port_do_dir = 1, port_ck_bit = 0, port_ck_dir = 0;
  logic [5:0] io_addr = 0;
  logic [7:0] io_wdata = 0, io_rdata, rx_data;
  logic       do_pin_o, do_pin_oe, do_pull_up, sck_pin_o, sck_pin_oe, ck_toggle, rx_valid;
  logic       start_irq_req, ovf_irq_req, pm_sck, pm_sdo, sck_line, sdo_line;
  int         n_fail = 0, total_checks = 0, cyc = 0;

  assign sck_line = sck_pin_oe ? sck_pin_o : pm_sck;
  assign sdo_line = do_pin_oe ? do_pin_o : do_pull_up;

  usu_shift_unit dut_u (.clk_sys, .rst_n, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .global_irq_en,
    .timer0_match, .start_detect, .start_flag_clr, .ovf_flag_clr, .serial_data_input(pm_sdo), .sck_pin_i(sck_line),
    .port_do_bit, .port_do_dir, .port_ck_bit, .port_ck_dir, .do_pin_o, .do_pin_oe, .do_pull_up, .sck_pin_o,
    .sck_pin_oe, .ck_toggle, .rx_data, .rx_valid, .rx_ready, .start_irq_req, .ovf_irq_req);
  usu_serial_master_model pm_u (.sck(pm_sck), .sdo(pm_sdo), .sdi(sdo_line));

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_fail++;
      summarize;
    end
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic do_reset;
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge clk_sys);
    io_wr <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge clk_sys);
    io_rd <= 1'b0;
    @(negedge clk_sys);
    d = io_rdata;
  endtask

  task automatic pop(input logic [7:0] exp);
    @(negedge clk_sys);
    chk("rx valid", rx_valid, 1);
    chk("rx data", rx_data, exp);
    @(posedge clk_sys);
    rx_ready <= 1'b1;
    @(posedge clk_sys);
    rx_ready <= 1'b0;
  endtask

  task automatic t_regs;
    logic [7:0] v;
    rd(usu_pkg::ADDR_CTRL, v);
    chk("ctrl reset", v, 8'h00);
    wr(usu_pkg::ADDR_CTRL, 8'hff);
    rd(usu_pkg::ADDR_CTRL, v);
    chk("ctrl rw", v, 8'hfc);
    wr(usu_pkg::ADDR_DATA, PRE);
    rd(usu_pkg::ADDR_DATA, v);
    chk("data rw", v, PRE);
    rd(6'h0e, v);
    chk("unmapped", v, 8'h00);
    do_reset;
  endtask

  task automatic t_pins;
    @(posedge clk_sys);
    port_do_dir <= 1'b0;
    port_do_bit <= 1'b1;
    port_ck_dir <= 1'b1;
    port_ck_bit <= 1'b1;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("pull up", {do_pin_oe, do_pull_up}, 8'h01);
    chk("sck pin", {sck_pin_oe, sck_pin_o}, 8'h03);
    @(posedge clk_sys);
    port_do_dir <= 1'b1;
    port_ck_dir <= 1'b0;
    port_ck_bit <= 1'b0;
  endtask

  // Sixteen strobe-write or timer events; a zero event value means timer pulses
  task automatic run16(input logic [7:0] c0, input logic [7:0] c, input logic h, input logic [7:0] exp,
                       input logic chk_do);
    pm_u.hold(h);
    wr(usu_pkg::ADDR_DATA, PRE);
    wr(usu_pkg::ADDR_CTRL, c0);
    for (int i = 1; i <= 16; i++)
    begin
      if (c == 8'h00)
      begin
        @(posedge clk_sys);
        timer0_match <= 1'b1;
        @(posedge clk_sys);
        timer0_match <= 1'b0;
      end
      else
        wr(usu_pkg::ADDR_CTRL, c);
      @(negedge clk_sys);
      if (c != 8'h00)
        chk("toggle", ck_toggle, c[0]);
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      if (chk_do && i < 8)
        chk("do pin", do_pin_o, PRE[7-i]);
      chk("wrap", rx_valid, i == 16);
    end
    pop(exp);
  endtask

  task automatic t_irq;
    @(negedge clk_sys);
    chk("ovf masked", ovf_irq_req, 0);
    @(posedge clk_sys);
    global_irq_en <= 1'b1;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("ovf pending", ovf_irq_req, 1);
    @(posedge clk_sys);
    ovf_flag_clr <= 1'b1;
    start_detect <= 1'b1;
    @(posedge clk_sys);
    ovf_flag_clr <= 1'b0;
    start_detect <= 1'b0;
    io_addr <= usu_pkg::ADDR_CTRL;
    io_wdata <= 8'h80;
    io_wr <= 1'b1;
    @(posedge clk_sys);
    io_wr <= 1'b0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("ovf cleared", ovf_irq_req, 0);
    chk("start pending", start_irq_req, 1);
    @(posedge clk_sys);
    start_flag_clr <= 1'b1;
    @(posedge clk_sys);
    start_flag_clr <= 1'b0;
    global_irq_en <= 1'b0;
  endtask

  task automatic ext(input logic [7:0] c, input logic [7:0] tx, input logic chk_do, input logic [7:0] exp_do,
                     input logic pop_it);
    logic [7:0] r;
    wr(usu_pkg::ADDR_CTRL, c);
    wr(usu_pkg::ADDR_DATA, 8'hc3);
    pm_u.xfer(tx, r);
    repeat (8) @(posedge clk_sys);
    if (chk_do)
      chk("slave rx", r, exp_do);
    if (pop_it)
      pop(tx);
  endtask

  task automatic t_buf;
    ext(8'h18, 8'h96, 1, 8'hc3, 0);
    ext(8'h18, 8'h69, 1, 8'hc3, 0);
    ext(8'h18, 8'hf0, 1, 8'hc3, 0);
    pop(8'h96);
    pop(8'h69);
    @(negedge clk_sys);
    chk("rx empty", rx_valid, 0);
  endtask

  initial
  begin
    do_reset;
    t_regs;
    t_pins;
    run16(8'h50, 8'h52, 1'b1, 8'hff, 1'b1);
    t_irq;
    run16(8'h54, 8'h00, 1'b0, 8'h00, 1'b0);
    run16(8'h1a, 8'h1b, 1'b1, 8'hff, 1'b0);
    ext(8'h08, 8'h5e, 1'b1, 8'hff, 1'b1);
    ext(8'h1c, 8'ha7, 1'b0, 8'h00, 1'b1);
    t_buf;
    summarize;
  end
endmodule // testbench
